// ---- core/sal_socket_activity_led.v ----
// socket activity led: retriggerable indication timer with suppression
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`include "sal_defs.vh"

module sal_socket_activity_led #(
    parameter PERIOD_TICKS = `SAL_PERIOD_TICKS,
    parameter CNT_W        = `SAL_CNT_W
) (
    // clock, reset, enable
    input  wire                      ref_clk,
    input  wire                      reset,
    input  wire                      clk_en,
    // socket state (from socket logic, same clock)
    input  wire                      card_present,
    input  wire                      card_powered,
    input  wire                      card_in_reset,
    input  wire                      card_type,
    // card-side activity pins, active low as on the bus
    input  wire                      card_ready_irq_line,
    input  wire                      cframe_n,
    input  wire                      irdy_n,
    input  wire                      creq_n,
    // power management (same clock)
    input  wire                      suspend,
    input  wire                      clkrun_stop,
    input  wire                      pm_d1,
    input  wire                      pm_d2,
    // pin routing
    input  wire [`SAL_MFP_SEL_W-1:0] mfp_sel,
    // outputs
    output wire                      multifunction_pin,
    output wire                      socket_a_activity_led,
    output wire                      socket_led_compat_out
);
    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    localparam NUM_PINS = 4;
    localparam NUM_LED  = 2;

    wire [NUM_PINS-1:0] pins_raw;
    wire [NUM_PINS-1:0] pins_sync;
    wire [NUM_PINS-1:0] pins_low;

    // bit order fixes which bit each decode below reads:
    // 3 ready/irq, 2 frame, 1 irdy, 0 creq
    assign pins_raw = {card_ready_irq_line, cframe_n, irdy_n, creq_n};

    // idle value of every pin is high, so reset value 0 would fake activity
    // for two cycles; masked by card_seen below
    sal_sync2 #(
        .W (NUM_PINS)
    ) u_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .clk_en  (clk_en),
        .din     (pins_raw),
        .dout    (pins_sync)
    );

    // every card pin is active low; turn each into an asserted flag
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
            assign pins_low[gi] = ~pins_sync[gi];
        end
    endgenerate

    // ---------------------------------------------------------------
    // synchroniser warm-up
    // ---------------------------------------------------------------
    // two enabled edges after reset the synchronisers hold real pin values;
    // until then their reset zeros must not count as activity
    reg [1:0] warm_ff;
    wire      card_seen;

    assign card_seen = warm_ff[1];

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            warm_ff <= 2'h0;
        end else if (clk_en) begin
            warm_ff <= {warm_ff[0], 1'b1};
        end
    end

    // ---------------------------------------------------------------
    // activity decode
    // ---------------------------------------------------------------
    // picks the pins that count for the card type in the socket; pins
    // that belong to the other card type carry other signals and are ignored
    function act_decode;
        input       kind;
        input [3:0] low;
        begin
            if (kind == `SAL_CARD_CARDBUS) begin
                act_decode = low[2] | low[1] | low[0];
            end else begin
                act_decode = low[3];
            end
        end
    endfunction

    wire socket_live;
    wire act_raw;
    wire activity;

    assign socket_live = card_present & card_powered & ~card_in_reset;
    assign act_raw     = act_decode(card_type, pins_low);
    assign activity    = card_seen & socket_live & act_raw;

    // ---------------------------------------------------------------
    // suppression
    // ---------------------------------------------------------------
    // any of these may stop the bus clock, which would freeze the timer
    // with the led on; cutting the led here avoids that stuck state
    wire suppress;

    assign suppress = suspend | clkrun_stop | pm_d1 | pm_d2;

    // ---------------------------------------------------------------
    // indication timer
    // ---------------------------------------------------------------
    // terminal count, cut to the counter width on purpose; CNT_W must be
    // wide enough for PERIOD_TICKS or the period silently shortens
    localparam [31:0]      LAST_TICK_W = PERIOD_TICKS - 1;
    localparam [CNT_W-1:0] LAST_TICK   = LAST_TICK_W[CNT_W-1:0];

    reg  [CNT_W-1:0] cnt_ff;
    reg              led_ff;
    reg  [CNT_W-1:0] nxt_cnt;
    reg              nxt_led;
    wire             period_done;

    assign period_done = led_ff & (cnt_ff == LAST_TICK);

    always @* begin
        nxt_cnt = cnt_ff;
        nxt_led = led_ff;
        if (suppress) begin
            // cut off so a stopped bus clock cannot leave the led stuck on
            nxt_cnt = {CNT_W{1'b0}};
            nxt_led = 1'b0;
        end else if (activity) begin
            // retrigger: a busy socket keeps the led on without a gap
            nxt_cnt = {CNT_W{1'b0}};
            nxt_led = 1'b1;
        end else if (period_done) begin
            nxt_cnt = {CNT_W{1'b0}};
            nxt_led = 1'b0;
        end else if (led_ff) begin
            nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt_ff <= {CNT_W{1'b0}};
            led_ff <= `SAL_LED_RESET;
        end else if (clk_en) begin
            cnt_ff <= nxt_cnt;
            led_ff <= nxt_led;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // both led outputs come straight from the one register, so they can
    // never disagree; the compat copy exists only for older boards
    wire [NUM_LED-1:0] led_bus;

    generate
        for (gi = 0; gi < NUM_LED; gi = gi + 1) begin : g_led
            assign led_bus[gi] = led_ff;
        end
    endgenerate

    assign socket_a_activity_led = led_bus[0];
    assign socket_led_compat_out = led_bus[1];

    // pin driven low, never floated, when not routed to the led
    wire led_routed;

    assign led_routed        = (mfp_sel == `SAL_MFP_SEL_LED);
    assign multifunction_pin = led_routed & led_ff;
endmodule // sal_socket_activity_led

// ---- core/sal_sync2.v ----
// two-flop synchroniser bank for inputs from outside the clock domain
module sal_sync2 #(
    parameter W = 1
) (
    // clock and reset
    input  wire         ref_clk,
    input  wire         reset,
    input  wire         clk_en,
    // data
    input  wire [W-1:0] din,
    output wire [W-1:0] dout
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta_ff <= {W{1'b0}};
            sync_ff <= {W{1'b0}};
        end else if (clk_en) begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule // sal_sync2

// ---- dv/sal_card_model.sv ----
// behavioural card in the socket driving the activity pins
module sal_card_model (
    input logic ref_clk,
    input logic [2:0] kick,
    output logic card_ready_irq_line = 1'b1, cframe_n = 1'b1, irdy_n = 1'b1, creq_n = 1'b1
);
    timeunit 1ns; timeprecision 1ps;
    // one-cycle low strobe; pulled up between strobes
    always @(posedge ref_clk) begin
        card_ready_irq_line <= kick != 3'h1;
        cframe_n <= kick != 3'h2;
        irdy_n <= kick != 3'h3;
        creq_n <= kick != 3'h4;
    end
endmodule // sal_card_model

// ---- dv/sal_led_chk_assertions.sv ----
// concurrent checks on the socket activity led ports
module sal_led_chk #(parameter PERIOD_TICKS = 20) (
    input logic ref_clk, reset, clk_en, card_present, card_powered, card_in_reset, card_type,
    input logic card_ready_irq_line, cframe_n, irdy_n, creq_n, suspend, clkrun_stop, pm_d1, pm_d2,
    input logic [3:0] mfp_sel,
    input logic multifunction_pin, socket_a_activity_led, socket_led_compat_out
);
    logic [7:0] idle_ff;
    wire led = socket_a_activity_led;
    wire supp = suspend | clkrun_stop | pm_d1 | pm_d2;
    wire act = card_present & card_powered & ~card_in_reset &
               (card_type ? ~(cframe_n & irdy_n & creq_n) : ~card_ready_irq_line);
    // cycles since live activity, saturating so an idle socket never wraps back to recent
    always_ff @(posedge ref_clk or posedge reset)
        if (reset) idle_ff <= 8'hff;
        else if (!clk_en) idle_ff <= idle_ff;
        else if (act) idle_ff <= 8'h00;
        else if (idle_ff != 8'hff) idle_ff <= idle_ff + 8'h01;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_rise; $rose(led); endsequence
    a_compat_mirror: assert property (socket_led_compat_out == led) else $error("compat out differs");
    a_mfp_route: assert property (multifunction_pin == (led && mfp_sel == 4'h2)) else $error("pin route");
    a_supp_off: assert property (supp && clk_en |=> !led) else $error("led not cut");
    a_rise_cause: assert property (s_rise |-> $past(idle_ff) <= 8'd4) else $error("led rose idle");
    a_late_fall: assert property (led |-> idle_ff <= PERIOD_TICKS + 4) else $error("led held long");
    a_early_fall: assert property ($fell(led) && !$past(supp) |-> $past(idle_ff) >= PERIOD_TICKS)
        else $error("led fell early");
    a_stay_on: assert property (led && !supp && idle_ff < 8'd10 |=> led) else $error("led dropped");
    a_reset_clear: assert property ($fell(reset) |-> !led && !multifunction_pin) else $error("not clear");
    a_freeze_hold: assert property (!clk_en |=> $stable(led)) else $error("led moved frozen");
endmodule // sal_led_chk

// ---- dv/socket_activity_led_test.sv ----
// self-checking bench for the socket activity led block
module socket_activity_led_test;
    timeunit 1ns; timeprecision 1ps;
    logic ref_clk = 0, reset = 1, card_type = 0, card_present = 0, card_powered = 0, card_in_reset = 0;
    logic suspend = 0, clkrun_stop = 0, pm_d1 = 0, pm_d2 = 0;
    logic [3:0] mfp_sel = 4'h2;
    logic [2:0] kick = 3'h0;
    logic clk_en = 1;
    wire card_ready_irq_line, cframe_n, irdy_n, creq_n, multifunction_pin, socket_a_activity_led;
    wire socket_led_compat_out;
    int bad_count = 0, checked = 0;
    // {expect, type, kick[2:0], present powered in_reset, suppress[3:0], mfp_sel}
    logic [15:0] rows [14] = '{16'h8e02, 16'hd602, 16'hde02, 16'he602, 16'h1602, 16'h4e02, 16'h0a02,
                               16'h0c02, 16'h0f02, 16'h0e82, 16'h0e42, 16'h0e22, 16'h0e12, 16'h8e00};
    always #2.5 ref_clk = ~ref_clk;
    sal_card_model u_card (.*);
    sal_socket_activity_led #(.PERIOD_TICKS(20)) u_dut (.*);
    task automatic chk(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic tick(input int n); repeat (n) @(posedge ref_clk); endtask
    task automatic hit(input logic [2:0] k); kick <= k; tick(1); kick <= 3'h0; endtask
    task automatic summarize;
        if (bad_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        tick(12);
        reset <= 0;
        tick(1);
        chk("led_after_reset", 0, socket_a_activity_led);
        foreach (rows[i]) begin
            {card_type, card_present, card_powered, card_in_reset, suspend, clkrun_stop, pm_d1, pm_d2, mfp_sel}
                <= {rows[i][14], rows[i][10:0]};
            tick(2);
            hit(rows[i][13:11]);
            tick(8);
            chk("led", rows[i][15], socket_a_activity_led);
            chk("compat", rows[i][15], socket_led_compat_out);
            chk("mfp_pin", rows[i][15] && rows[i][3:0] == 4'h2, multifunction_pin);
            tick(30);
            chk("led_idle", 0, socket_a_activity_led);
        end
        {card_present, card_powered, suspend, clkrun_stop, pm_d1, pm_d2} <= 6'h30;
        hit(3'h1);
        repeat (5) begin
            tick(15);
            chk("retrigger_on", 1, socket_a_activity_led);
            hit(3'h1);
        end
        tick(18);
        chk("period_on", 1, socket_a_activity_led);
        tick(10);
        chk("period_off", 0, socket_a_activity_led);
        hit(3'h1);
        tick(6);
        clk_en <= 0;
        tick(30);
        chk("freeze_on", 1, socket_a_activity_led);
        clk_en <= 1;
        tick(30);
        chk("freeze_off", 0, socket_a_activity_led);
        hit(3'h1);
        tick(6);
        suspend <= 1;
        tick(2);
        chk("suspend_cut", 0, socket_a_activity_led);
        suspend <= 0;
        hit(3'h1);
        tick(6);
        reset <= 1;
        tick(2);
        chk("reset_cut", 0, socket_a_activity_led);
        reset <= 0;
        tick(3);
        chk("reset_idle", 0, socket_a_activity_led);
        hit(3'h1);
        tick(8);
        chk("reset_again_on", 1, socket_a_activity_led);
        summarize();
    end
    // about ten times the expected run
    initial begin
        #40000;
        bad_count++;
        summarize();
    end
endmodule // socket_activity_led_test
bind sal_socket_activity_led sal_led_chk #(.PERIOD_TICKS(PERIOD_TICKS)) u_chk (.*);

// ---- include/sal_defs.vh ----
// constants for the socket activity led block
`ifndef SAL_DEFS_VH
`define SAL_DEFS_VH
// indication period in ms and clock rate in kHz
`define SAL_PERIOD_MS      64
`define SAL_CLK_KHZ        200000
// ticks of ref_clk in one indication period
`define SAL_PERIOD_TICKS   (`SAL_PERIOD_MS * `SAL_CLK_KHZ)
`define SAL_CNT_W          24
// card type codes
`define SAL_CARD_16BIT     1'b0
`define SAL_CARD_CARDBUS   1'b1
// multifunction pin routing select that picks the led function
`define SAL_MFP_SEL_W      4
`define SAL_MFP_SEL_LED    4'h2
`define SAL_LED_RESET      1'b0
`endif
